//--- ccf_pkg.sv
// Constants for the CCD front end sample control block.
// Used by the top level, its assertions and the bench; no logic lives here.
package ccf_pkg;
	// Sample path and register port widths
	localparam int unsigned ADC_W      = 10;
	localparam int unsigned GAIN_W     = 10;
	localparam int unsigned BLK_W      = 4;
	localparam int unsigned REG_AW     = 3;
	localparam int unsigned REG_DW     = 12;

	// Register indices on the command port
	localparam logic [2:0] REG_CONFIG  = 3'h0;
	localparam logic [2:0] REG_GAIN    = 3'h1;
	localparam logic [2:0] REG_BLACK   = 3'h2;
	localparam logic [2:0] REG_POLAR   = 3'h3;

	// Field positions
	localparam int unsigned CFG_STANDBY_BIT = 0;
	localparam int unsigned CFG_DRIVE_BIT   = 8;
	localparam int unsigned POL_DUMMY_BIT   = 0;
	localparam int unsigned POL_BLACK_BIT   = 1;
	localparam int unsigned POL_STROBE_BIT  = 2;

	// Reset values
	localparam logic [GAIN_W-1:0] GAIN_RST  = 10'h080;
	localparam logic [BLK_W-1:0]  BLACK_RST = 4'h8;
	localparam logic [2:0]        POL_RST   = 3'h0;
	localparam logic              STANDBY_RST = 1'b0;
	localparam logic              DRIVE_RST   = 1'b0;

	// Gain law: each 128 codes doubles the gain, code 128 is unity
	localparam int unsigned GAIN_OCT_LSB  = 7;
	localparam logic [7:0]  GAIN_MANT_ONE = 8'h80;
	localparam int unsigned GAIN_NORM_SH  = 8;

	// Black pedestal is four output codes per step
	localparam int unsigned BLK_STEP_SH   = 2;

	// Output latency in master clock edges
	localparam int unsigned LAT_NORM      = 9;
	localparam int unsigned LAT_BLANK     = 11;
endpackage

//--- ccf_delay.sv
// Fixed-depth shift line with every stage exposed as a tap.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ccf_delay #(
	parameter int unsigned WIDTH = 11,
	parameter int unsigned DEPTH = 11
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     resetn,
	// Stream in
	input  wire logic [WIDTH-1:0]         din,
	// Stage k holds din from k+1 edges ago
	output logic      [DEPTH*WIDTH-1:0]   taps
);
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_stage
			logic [WIDTH-1:0] stage_r;
			if (g == 0) begin : g_first
				always_ff @(posedge clk or negedge resetn) begin
					if (!resetn) begin
						stage_r <= '0;
					end else begin
						stage_r <= din;
					end
				end
			end else begin : g_rest
				always_ff @(posedge clk or negedge resetn) begin
					if (!resetn) begin
						stage_r <= '0;
					end else begin
						stage_r <= g_stage[g-1].stage_r;
					end
				end
			end
			assign taps[g*WIDTH +: WIDTH] = stage_r;
		end
	endgenerate
endmodule
`default_nettype wire

//--- ccf_frontend.sv
// CCD front end sample control: strobe polarity, reference and data
// hold, subtraction, gain, black calibration loop, preblanking and the
// output latency line. Sensor samples arrive as already digitised words;
// every pin input is synchronised before use.
//
// Functional notes
// R1 - Reset low restores all settings asynchronously
// R2 - Track reference during strobe, hold at end
// R3 - Track data, hold at end, subtract reference
// R4 - Strobe polarity selectable, default active low
// R5 - Host programs settings or pulses reset
// R6 - Dummy clamp only when clamp and reference
// R7 - Dummy clamp polarity selectable, default low
// R8 - Output word is ten bits, all codes
// R9 - Ten-bit gain code, linear in dB
// R10 - Gain code resets to 128, unity
// R11 - Black loop adjusts only during black pulse
// R12 - Effective pixels keep the calibrated black
// R13 - Four-bit black code, four LSBs per step
// R14 - Black code resets to 1000, 32 LSB
// R15 - Black pulse polarity selectable, default low
// R16 - Preblank low disconnects the sensor input
// R17 - Outputs zero from eleventh edge after preblank
// R18 - Preblank mode latency is eleven cycles
// R19 - Normal latency is nine cycles
// R20 - Host never pulses black clamp during preblank
// R21 - Preblank high normal, low zero output
// R22 - Output always timed by master clock
// R23 - Three polarity bits, zero means active low
// R24 - Resume output once latency line refills
`timescale 1ns/1ps
`default_nettype none
module ccf_frontend #(
	parameter int unsigned ADC_W  = ccf_pkg::ADC_W,
	parameter int unsigned GAIN_W = ccf_pkg::GAIN_W
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      resetn,
	// Register port
	input  wire logic [ccf_pkg::REG_AW-1:0] reg_addr,
	input  wire logic [ccf_pkg::REG_DW-1:0] reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [ccf_pkg::REG_DW-1:0] reg_rdata,
	// Timing generator pins
	input  wire logic                      ref_sample_strobe,
	input  wire logic                      data_sample_strobe,
	input  wire logic                      dummy_clamp_pulse,
	input  wire logic                      black_clamp_pulse,
	input  wire logic                      preblank_n,
	// Digitised sensor level
	input  wire logic [ADC_W-1:0]          sensor_input,
	// Analog side controls
	output logic                           input_connect,
	output logic                           dummy_clamp_en,
	output logic                           black_loop_closed,
	output logic                           standby,
	output logic                           adc_drive_ext,
	// Sample output
	output logic      [ADC_W-1:0]          sample_out
);
	localparam int unsigned OFS_W = ADC_W + 2;
	localparam int unsigned LINE_W = ADC_W + 1;

	// Settings
	logic                  standby_r;
	logic                  drive_r;
	logic [GAIN_W-1:0]     gain_r;
	logic [ccf_pkg::BLK_W-1:0] black_r;
	logic [2:0]            pol_r;

	// Synchronisers: first stage feeds only the second
	logic [4:0]            pin_s1_r;
	logic [4:0]            pin_s2_r;
	logic [ADC_W-1:0]      sens_s1_r;
	logic [ADC_W-1:0]      sens_s2_r;

	// Sampling state
	logic                  ref_act_d_r;
	logic                  data_act_d_r;
	logic [ADC_W-1:0]      ref_hold_r;
	logic [ADC_W-1:0]      data_hold_r;
	logic [ADC_W-1:0]      ref_hold_nxt;
	logic [ADC_W-1:0]      data_hold_nxt;
	logic signed [OFS_W-1:0] blk_ofs_r;
	logic signed [OFS_W-1:0] blk_ofs_nxt;
	logic [ADC_W-1:0]      conv_r;
	logic                  blank_r;

	// Output stage
	logic                  input_connect_r;
	logic                  dummy_clamp_r;
	logic                  black_loop_r;
	logic [ADC_W-1:0]      sample_out_r;
	logic [ccf_pkg::REG_DW-1:0] rdata_r;

	// Register writes
	wire wr_config = reg_wr && (reg_addr == ccf_pkg::REG_CONFIG);
	wire wr_gain   = reg_wr && (reg_addr == ccf_pkg::REG_GAIN);
	wire wr_black  = reg_wr && (reg_addr == ccf_pkg::REG_BLACK);
	wire wr_polar  = reg_wr && (reg_addr == ccf_pkg::REG_POLAR);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			standby_r <= ccf_pkg::STANDBY_RST; // R1
			drive_r   <= ccf_pkg::DRIVE_RST;
			gain_r    <= ccf_pkg::GAIN_RST; // R10
			black_r   <= ccf_pkg::BLACK_RST; // R14
			pol_r     <= ccf_pkg::POL_RST; // R4 R7 R15
		end else begin
			if (wr_config) begin
				standby_r <= reg_wdata[ccf_pkg::CFG_STANDBY_BIT];
				drive_r   <= reg_wdata[ccf_pkg::CFG_DRIVE_BIT];
			end
			if (wr_gain) begin
				gain_r <= reg_wdata[GAIN_W-1:0]; // R9
			end
			if (wr_black) begin
				black_r <= reg_wdata[ccf_pkg::BLK_W-1:0]; // R13
			end
			if (wr_polar) begin
				pol_r <= reg_wdata[2:0]; // R23
			end
		end
	end

	// Register reads, answered in the next cycle; unmapped reads give zero
	logic [ccf_pkg::REG_DW-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (reg_addr == ccf_pkg::REG_CONFIG) begin
			rd_mux[ccf_pkg::CFG_STANDBY_BIT] = standby_r;
			rd_mux[ccf_pkg::CFG_DRIVE_BIT]   = drive_r;
		end else if (reg_addr == ccf_pkg::REG_GAIN) begin
			rd_mux[GAIN_W-1:0] = gain_r;
		end else if (reg_addr == ccf_pkg::REG_BLACK) begin
			rd_mux[ccf_pkg::BLK_W-1:0] = black_r;
		end else if (reg_addr == ccf_pkg::REG_POLAR) begin
			rd_mux[2:0] = pol_r;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= '0;
		end else if (reg_rd) begin
			rdata_r <= rd_mux;
		end else begin
			rdata_r <= '0;
		end
	end

	// Pin synchronisers
	wire [4:0] pins_raw = {preblank_n, black_clamp_pulse, dummy_clamp_pulse,
		data_sample_strobe, ref_sample_strobe};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// Idle levels under the reset polarity, so no false strobe or blank follows reset
			pin_s1_r  <= '1;
			pin_s2_r  <= '1;
			sens_s1_r <= '0;
			sens_s2_r <= '0;
		end else begin
			pin_s1_r  <= pins_raw;
			pin_s2_r  <= pin_s1_r;
			sens_s1_r <= sensor_input;
			sens_s2_r <= sens_s1_r;
		end
	end

	// A polarity bit of one means the pin is active high
	wire ref_act   = pin_s2_r[0] ~^ pol_r[ccf_pkg::POL_STROBE_BIT]; // R4 R23
	wire data_act  = pin_s2_r[1] ~^ pol_r[ccf_pkg::POL_STROBE_BIT]; // R4
	wire dummy_act = pin_s2_r[2] ~^ pol_r[ccf_pkg::POL_DUMMY_BIT]; // R7
	wire black_act = pin_s2_r[3] ~^ pol_r[ccf_pkg::POL_BLACK_BIT]; // R15
	wire blank     = ~pin_s2_r[4]; // R21

	// The data strobe's trailing edge marks the moment the data level is frozen
	wire data_trail = data_act_d_r && !data_act;

	// While blanked the sensor is cut off, so the holds keep their levels
	always_comb begin
		ref_hold_nxt  = ref_hold_r;
		data_hold_nxt = data_hold_r;
		if (!blank && ref_act) begin
			ref_hold_nxt = sens_s2_r; // R2 R16
		end
		if (!blank && data_act) begin
			data_hold_nxt = sens_s2_r; // R3 R16
		end
	end

	// The sensor swings below its reset level, so video is ref minus data
	wire signed [ADC_W:0] video_diff = $signed({1'b0, ref_hold_r}) - $signed({1'b0, data_hold_r}); // R3
	wire [ADC_W-1:0] video = video_diff[ADC_W] ? '0 : video_diff[ADC_W-1:0];

	// Gain: octave from the top code bits, straight-line mantissa between
	// octaves. This tracks dB linearly to within a fraction of a dB.
	localparam int unsigned OCT_W  = GAIN_W - ccf_pkg::GAIN_OCT_LSB;
	localparam int unsigned PROD_W = ADC_W + 8 + (1 << OCT_W) - 1;
	wire [OCT_W-1:0] gain_oct  = gain_r[GAIN_W-1:ccf_pkg::GAIN_OCT_LSB]; // R9
	wire [7:0]       gain_mant = ccf_pkg::GAIN_MANT_ONE
		| {1'b0, gain_r[ccf_pkg::GAIN_OCT_LSB-1:0]};
	// Widen both factors first; a self-sized product would wrap at ten bits
	wire [PROD_W-1:0] gain_prod = (PROD_W'(video) * PROD_W'(gain_mant)) << gain_oct;
	wire [PROD_W-1:0] gain_norm = gain_prod >> ccf_pkg::GAIN_NORM_SH;
	wire [OFS_W-1:0]  gained = (|gain_norm[PROD_W-1:ADC_W])
		? OFS_W'({ADC_W{1'b1}}) : OFS_W'(gain_norm[ADC_W-1:0]);

	// Black loop: the offset chases the black pixel level to zero
	wire signed [OFS_W-1:0] black_err = $signed(gained) - blk_ofs_r;
	wire [ADC_W-1:0] pedestal = ADC_W'({black_r, {ccf_pkg::BLK_STEP_SH{1'b0}}}); // R13

	always_comb begin
		blk_ofs_nxt = blk_ofs_r;
		if (black_act && !blank && data_trail) begin // R11
			if (black_err > 0) begin
				blk_ofs_nxt = blk_ofs_r + OFS_W'(1);
			end else if (black_err < 0) begin
				blk_ofs_nxt = blk_ofs_r - OFS_W'(1);
			end
		end
	end

	// Effective pixels reuse the held offset untouched
	wire signed [OFS_W:0] level = $signed({black_err[OFS_W-1], black_err})
		+ $signed({2'b00, pedestal}); // R12
	wire [ADC_W-1:0] conv_nxt = level[OFS_W] ? '0
		: (|level[OFS_W-1:ADC_W]) ? {ADC_W{1'b1}} : level[ADC_W-1:0]; // R8

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ref_act_d_r  <= 1'b0;
			data_act_d_r <= 1'b0;
			ref_hold_r   <= '0;
			data_hold_r  <= '0;
			blk_ofs_r    <= '0;
			conv_r       <= '0;
			blank_r      <= 1'b0;
		end else begin
			ref_act_d_r  <= ref_act;
			data_act_d_r <= data_act;
			ref_hold_r   <= ref_hold_nxt;
			data_hold_r  <= data_hold_nxt;
			blk_ofs_r    <= blk_ofs_nxt;
			conv_r       <= conv_nxt;
			blank_r      <= blank;
		end
	end

	// Latency line carries each word with its blanking flag
	logic [ccf_pkg::LAT_BLANK*LINE_W-1:0] line_taps;

	ccf_delay #(
		.WIDTH (LINE_W),
		.DEPTH (ccf_pkg::LAT_BLANK)
	) u_line (
		.clk    (clk),
		.resetn (resetn),
		.din    ({blank_r, conv_r}),
		.taps   (line_taps)
	);

	wire [LINE_W-1:0] tap_norm  = line_taps[(ccf_pkg::LAT_NORM-1)*LINE_W +: LINE_W]; // R19
	wire [LINE_W-1:0] tap_blank = line_taps[(ccf_pkg::LAT_BLANK-1)*LINE_W +: LINE_W]; // R18
	wire blank_reached = tap_blank[ADC_W]; // R17 R24
	wire [ADC_W-1:0] out_sel = blank_r ? tap_blank[ADC_W-1:0] : tap_norm[ADC_W-1:0];
	// The flag keeps zeros flowing until the line has refilled
	wire [ADC_W-1:0] out_nxt = blank_reached ? '0 : out_sel; // R17 R21 R24

	// Outputs change only on clk edges, whatever drive mode is set
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sample_out_r    <= '0;
			input_connect_r <= 1'b0;
			dummy_clamp_r   <= 1'b0;
			black_loop_r    <= 1'b0;
		end else begin
			sample_out_r    <= out_nxt; // R22
			input_connect_r <= !blank; // R16
			dummy_clamp_r   <= dummy_act && ref_act; // R6
			black_loop_r    <= black_act && !blank; // R11
		end
	end

	assign reg_rdata         = rdata_r;
	assign sample_out        = sample_out_r;
	assign input_connect     = input_connect_r;
	assign dummy_clamp_en    = dummy_clamp_r;
	assign black_loop_closed = black_loop_r;
	assign standby           = standby_r;
	assign adc_drive_ext     = drive_r;
endmodule
`default_nettype wire

//--- ccf_partner.sv
// Timing generator and sensor model: eight-cycle pixel, reference strobe then data strobe.
// Assumes the bench supplies polarity, clamp and blank requests and the two pixel levels.
`timescale 1ns/1ps
`default_nettype none
module ccf_partner (
	// Clock
	input	wire logic		clk,
	// Requests from the bench
	input	wire logic [2:0]	pol,
	input	wire logic		blank_req,
	input	wire logic		black_req,
	input	wire logic		dummy_req,
	input	wire logic [9:0]	lvl_ref,
	input	wire logic [9:0]	lvl_data,
	// Pins
	output	logic			ref_sample_strobe,
	output	logic			data_sample_strobe,
	output	logic			dummy_clamp_pulse,
	output	logic			black_clamp_pulse,
	output	logic			preblank_n,
	output	logic [9:0]		sensor_input
);
	logic [2:0]	ph_r = 3'h0;
	always_ff @(posedge clk) begin
		ph_r <= ph_r + 3'h1;
	end
	// Level is steady around each strobe, so either hold edge sees one value
	assign sensor_input = (ph_r < 3'h4) ? lvl_ref : lvl_data;
	assign ref_sample_strobe = (ph_r == 3'h1) ~^ pol[2];
	assign data_sample_strobe = (ph_r == 3'h5) ~^ pol[2];
	assign dummy_clamp_pulse = dummy_req ~^ pol[0];
	// Black clamp is suppressed while blanking so the loop never sees a blanked pixel
	assign black_clamp_pulse = (black_req & ~blank_req) ~^ pol[1];
	assign preblank_n = ~blank_req;
endmodule
`default_nettype wire

//--- ccf_frontend_assertions.sv
// Timing checks on the front end ports.
// Assumes the bench keeps the dummy and strobe polarity bits equal.
`timescale 1ns/1ps
`default_nettype none
module ccf_frontend_assertions (
	input	wire logic				clk,
	input	wire logic				resetn,
	input	wire logic [ccf_pkg::REG_AW-1:0]	reg_addr,
	input	wire logic [ccf_pkg::REG_DW-1:0]	reg_wdata,
	input	wire logic				reg_wr,
	input	wire logic [ccf_pkg::REG_DW-1:0]	reg_rdata,
	input	wire logic				preblank_n,
	input	wire logic				ref_sample_strobe,
	input	wire logic				dummy_clamp_pulse,
	input	wire logic				black_clamp_pulse,
	input	wire logic				input_connect,
	input	wire logic				dummy_clamp_en,
	input	wire logic				black_loop_closed,
	input	wire logic				adc_drive_ext,
	input	wire logic [ccf_pkg::ADC_W-1:0]	sample_out
);
	default clocking cb @(posedge clk); endclocking
	// Consecutive cycles with blanking requested at the pin, saturating
	logic [4:0]	blank_cnt_r;
	logic [4:0]	blank_cnt_nxt;
	assign blank_cnt_nxt = preblank_n ? 5'h00 : ((blank_cnt_r == 5'h1f) ? blank_cnt_r : blank_cnt_r + 5'h01);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			blank_cnt_r <= 5'h00;
		end else begin
			blank_cnt_r <= blank_cnt_nxt;
		end
	end
	a_reset_clears: assert property (!resetn |-> sample_out == '0 && reg_rdata == '0) else $error("reset outputs");
	a_blank_disconnect: assert property (disable iff (!resetn) blank_cnt_r >= 5'h04 |-> !input_connect)
		else $error("input left connected");
	a_normal_connect: assert property (disable iff (!resetn) preblank_n[*5] ##0 $past(resetn, 5) |-> input_connect)
		else $error("input not connected");
	a_blank_zero: assert property (disable iff (!resetn) blank_cnt_r >= 5'h0f |-> sample_out == '0)
		else $error("blanked output not zero");
	a_no_loop_blank: assert property (disable iff (!resetn) blank_cnt_r >= 5'h04 |-> !black_loop_closed)
		else $error("loop closed while blanked");
	a_dummy_both: assert property (disable iff (!resetn)
		dummy_clamp_en |-> $past(dummy_clamp_pulse, 3) == $past(ref_sample_strobe, 3))
		else $error("dummy clamp without both");
	a_loop_follows_pin: assert property (disable iff (!resetn)
		$rose(black_loop_closed) |-> $past(black_clamp_pulse, 3) != $past(black_clamp_pulse, 4))
		else $error("loop closed without pulse edge");
	a_drive_bit: assert property (disable iff (!resetn)
		reg_wr && reg_addr == ccf_pkg::REG_CONFIG && reg_wdata[8] |-> ##[1:2] adc_drive_ext)
		else $error("drive bit not applied");
endmodule
bind ccf_frontend ccf_frontend_assertions u_chk (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
	.preblank_n, .ref_sample_strobe, .dummy_clamp_pulse, .black_clamp_pulse, .input_connect,
	.dummy_clamp_en, .black_loop_closed, .adc_drive_ext, .sample_out);
`default_nettype wire

//--- tb_ccf_frontend.sv
// Self-checking bench for the front end: registers, pedestal, gain, black loop, blanking, polarity.
// Assumes the partner model drives every pin and the black offset starts at zero.
`timescale 1ns/1ps
`default_nettype none
module tb_ccf_frontend;
	logic clk = 1'b0, resetn = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [2:0] reg_addr = 3'h0, pol = 3'h0;
	logic [11:0] reg_wdata = 12'h000;
	logic blank_req = 1'b0, black_req = 1'b0, dummy_req = 1'b0;
	logic [9:0] lvl_ref = 10'h0c8, lvl_data = 10'h0c8;
	wire logic rs, ds, dp, bp, pb, ic, de, bl, sb, ae;
	wire logic [9:0] si, so;
	wire logic [11:0] rdata;
	int failures = 0, compares = 0;
	ccf_partner u_far (.clk, .pol, .blank_req, .black_req, .dummy_req, .lvl_ref, .lvl_data,
		.ref_sample_strobe(rs), .data_sample_strobe(ds), .dummy_clamp_pulse(dp),
		.black_clamp_pulse(bp), .preblank_n(pb), .sensor_input(si));
	ccf_frontend u_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata),
		.ref_sample_strobe(rs), .data_sample_strobe(ds), .dummy_clamp_pulse(dp), .black_clamp_pulse(bp),
		.preblank_n(pb), .sensor_input(si), .input_connect(ic), .dummy_clamp_en(de),
		.black_loop_closed(bl), .standby(sb), .adc_drive_ext(ae), .sample_out(so));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [11:0] d);
		@(posedge clk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [11:0] exp);
		@(posedge clk);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk) check("reg_rdata", exp, rdata);
	endtask
	// Black loop may dither by up to three codes either side of the pedestal
	task automatic near_ped(input string what);
		@(negedge clk) check(what, 12'h001, {11'h000, so >= 10'h01d && so <= 10'h023});
	endtask
	task automatic t_regs;
		rd(ccf_pkg::REG_GAIN, 12'h080);
		rd(ccf_pkg::REG_BLACK, 12'h008);
		rd(ccf_pkg::REG_POLAR, 12'h000);
		rd(ccf_pkg::REG_CONFIG, 12'h000);
		wr(3'h4, 12'hfff);
		rd(3'h4, 12'h000);
		wr(ccf_pkg::REG_CONFIG, 12'h100);
		repeat (2) @(posedge clk);
		@(negedge clk) check("drive", 12'h001, {11'h000, ae});
		check("standby", 12'h000, {11'h000, sb});
		wr(ccf_pkg::REG_CONFIG, 12'h000);
	endtask
	task automatic t_pedestal;
		logic [3:0] codes [4] = '{4'h0, 4'h1, 4'hf, 4'h8};
		logic [9:0] old;
		old = 10'h020;
		foreach (codes[i]) begin
			wr(ccf_pkg::REG_BLACK, {8'h00, codes[i]});
			repeat (6) @(posedge clk);
			@(negedge clk) check("early", {2'h0, old}, {2'h0, so});
			repeat (6) @(posedge clk);
			old = {4'h0, codes[i], 2'h0};
			@(negedge clk) check("pedestal", {2'h0, old}, {2'h0, so});
		end
	endtask
	task automatic t_gain;
		logic [9:0] codes [3] = '{10'h080, 10'h100, 10'h000};
		logic [9:0] exps [3] = '{10'h084, 10'h0e8, 10'h052};
		lvl_ref <= 10'h12c;
		foreach (codes[i]) begin
			wr(ccf_pkg::REG_GAIN, {2'h0, codes[i]});
			repeat (20) @(posedge clk);
			@(negedge clk) check("gain", {2'h0, exps[i]}, {2'h0, so});
		end
		wr(ccf_pkg::REG_GAIN, 12'h080);
	endtask
	task automatic t_loop;
		black_req <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk) check("loop", 12'h001, {11'h000, bl});
		repeat (1200) @(posedge clk);
		near_ped("calibrated");
		black_req <= 1'b0;
		repeat (200) @(posedge clk);
		near_ped("held");
	endtask
	task automatic t_blank;
		blank_req <= 1'b1;
		repeat (20) @(posedge clk);
		@(negedge clk) check("blank", 12'h000, {2'h0, so});
		check("connect", 12'h000, {11'h000, ic});
		blank_req <= 1'b0;
		repeat (30) @(posedge clk);
		near_ped("resume");
		check("connect", 12'h001, {11'h000, ic});
	endtask
	task automatic t_polarity;
		logic [2:0] pols [2] = '{3'h7, 3'h0};
		logic seen;
		foreach (pols[i]) begin
			// Pin and register polarity meet at the synchroniser output on one edge
			@(posedge clk);
			pol <= pols[i];
			wr(ccf_pkg::REG_POLAR, {9'h000, pols[i]});
			repeat (100) @(posedge clk);
			near_ped("polarity");
			@(posedge clk);
			dummy_req <= 1'b1;
			repeat (4) @(posedge clk);
			// Clamp enable follows the reference strobe, once per pixel
			seen = 1'b0;
			repeat (10) @(negedge clk) seen = seen | de;
			check("dummy", 12'h001, {11'h000, seen});
			@(posedge clk);
			dummy_req <= 1'b0;
			repeat (4) @(posedge clk);
			seen = 1'b0;
			repeat (10) @(negedge clk) seen = seen | de;
			check("dummy", 12'h000, {11'h000, seen});
		end
	endtask
	task automatic report_and_stop;
		if (failures == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#400000;
		failures++;
		report_and_stop;
	end
	initial begin
		resetn <= 1'b0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		t_regs;
		t_pedestal;
		t_gain;
		t_loop;
		t_blank;
		t_polarity;
		report_and_stop;
	end
endmodule
`default_nettype wire
